// file: sdl_consts.vh
// Constants for the strobe delay lock loop
// Behaviour
// (RL1) Loop tracks a frequency reference continuously to compensate drift.
// (RL2) Delay setting output is Gray coded; one bit changes per step.
// (RL3) Low-jitter mode locks after 2,560 reference cycles; code counts core clock cycles.
// (RL4) Normal mode locks within 512 reference cycles; code locks 513 core clock cycles after reset.
// (RL5) Traffic source should hold off read data during lock interval.
// (RL6) Setting consumers treat setting as unstable until lock elapses.
// (RL7) Usable below 100 MHz; strobe shift limited to 2.5 ns; code caps setting at SHIFT_CAP, 127 core clock cycles.
// (RL8) Up to four loops, one per corner, one frequency each.
// (RL9) Each loop gives two offset outputs, eight settings per device.
// (RL10) A loop drives settings into banks on both adjacent sides.
// (RL11) Each bank accepts settings from either or both adjacent loops.
// (RL12) Each strobe pin selects exactly one of two loop outputs.
// (RL13) One leveling chain per sub-bank: one interface per sub-bank.
// (RL14) Reference clock selects PLL output or dedicated clock pin.
// (RL15) Reference passes up to eight delay elements set by setting; code sets chain length from chain_used_in, not from setting.
// (RL16) Phase comparator compares chain output to reference, gives up/down; code compares setting to measured reference period.
// (RL17) Up/down moves seven-bit Gray counter until chain and reference align; code steps a binary counter until it equals the capped period.
// (RL18) Offset-adjusted settings go only to per-pin strobe logic.
// (RL19) Raw setting goes to core, strobe logic and read FIFO.
// (RL20) Strobe logic applies each new setting at all pins together.
// (RL21) Offset is Gray-coded two's complement -128..+127 with sign bit.
// (RL22) Combined delay is setting plus offset, capped at 128.
// (RL23) Lock indication after mode count since reset; cleared on reset.
// (RL24) Counter saturates at minimum and maximum, never wraps.
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH
`define SDL_SET_W        7
`define SDL_OFS_W        8
`define SDL_SUM_W        9
`define SDL_SET_MAX      7'h7f
`define SDL_SET_RST      7'h00
`define SDL_SUM_CAP      9'h080
`define SDL_LOCK_LJ      2560
`define SDL_LOCK_NORM    512
`define SDL_CHAIN_MAX    8
`define SDL_CLK_MHZ      250
`define SDL_SHIFT_MAX_PS 2500
`define SDL_SHIFT_MAX_CYC ((`SDL_SHIFT_MAX_PS * `SDL_CLK_MHZ) / 1000000)
`define SDL_UPD_GAP      4
`endif

// file: sdl_loop.v
// Strobe delay lock loop: comparator, binary counter with Gray output, lock timer, outputs
`timescale 1ns/10ps
`default_nettype none
`include "sdl_consts.vh"
module sdl_loop #(
    parameter integer LOCK_LJ_CYC   = `SDL_LOCK_LJ,
    parameter integer LOCK_NORM_CYC = `SDL_LOCK_NORM,
    parameter integer CHAIN_LEN     = `SDL_CHAIN_MAX,
    parameter integer SHIFT_CAP     = 127
) (
    input  wire                    core_clk_in,
    input  wire                    rstn_in,
    input  wire                    low_jitter_in,
    input  wire                    ref_sel_pin_in,
    input  wire                    ref_pll_in,
    input  wire                    ref_pin_in,
    input  wire [3:0]              chain_used_in,
    input  wire [`SDL_OFS_W-1:0]   offset_a_gray_in,
    input  wire                    offset_a_neg_in,
    input  wire [`SDL_OFS_W-1:0]   offset_b_gray_in,
    input  wire                    offset_b_neg_in,
    output reg  [`SDL_SET_W-1:0]   setting_gray_out,
    output wire [`SDL_SET_W:0]     side_a_setting_out,
    output wire [`SDL_SET_W:0]     side_b_setting_out,
    output reg                     update_out,
    output reg                     locked_out
);
    localparam integer CNT_W = 13;
    localparam [2:0] ST_LOCKING = 3'b001;
    localparam [2:0] ST_TRACK   = 3'b010;
    localparam [2:0] ST_IDLE    = 3'b100;

    reg  [2:0]            state_q;
    reg  [2:0]            state_d;
    reg  [`SDL_SET_W-1:0] set_bin_q;
    reg  [`SDL_SET_W-1:0] set_bin_d;
    reg  [CNT_W-1:0]      lock_cnt_q;
    reg  [CNT_W-1:0]      lock_target;
    reg  [2:0]            upd_cnt_q;
    reg                   ref_q;
    reg                   ref_prev_q;
    reg  [CHAIN_LEN-1:0]  chain_q;
    reg  [`SDL_SET_W-1:0] tap_cnt_q;
    reg  [`SDL_SET_W-1:0] phase_q;
    reg  [`SDL_SET_W-1:0] period_q;
    reg  [`SDL_SET_W-1:0] target;
    reg  [`SDL_SET_W-1:0] cap_val;
    wire                  ref_sel;
    wire                  ref_rise;
    wire                  chain_out;
    reg                   up;
    reg                   down;

    // Reference source mux
    assign ref_sel = ref_sel_pin_in ? ref_pin_in : ref_pll_in; // see (RL14)
    assign ref_rise = ref_q & ~ref_prev_q;

    // Delay element chain model: reference shifted through taps
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ref_q      <= 1'b0;
            ref_prev_q <= 1'b0;
            chain_q    <= {CHAIN_LEN{1'b0}};
        end else begin
            ref_q      <= ref_sel;
            ref_prev_q <= ref_q;
            chain_q    <= {chain_q[CHAIN_LEN-2:0], ref_q}; // see (RL15)
        end
    end
    // Used chain length is 2*(chain_used_in[2:0]+1) capped at CHAIN_LEN
    assign chain_out = chain_q[(chain_used_in[2:0] >= (CHAIN_LEN/2))
                               ? (CHAIN_LEN-1)
                               : ({chain_used_in[2:0], 1'b1})];

    // Measure reference period and chain phase in clock cycles
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            tap_cnt_q <= `SDL_SET_RST;
            phase_q   <= `SDL_SET_RST;
            period_q  <= `SDL_SET_RST;
        end else begin
            if (ref_rise) begin
                // Count from one so period_q holds the whole period
                tap_cnt_q <= 7'h01;
                period_q  <= tap_cnt_q; // see (RL1) (RL8)
            end else if (tap_cnt_q != `SDL_SET_MAX) begin
                tap_cnt_q <= tap_cnt_q + 7'h01;
            end
            if (chain_out && !chain_q[CHAIN_LEN-1]) begin
                phase_q <= tap_cnt_q;
            end
        end
    end

    // Phase comparator: setting should track measured period
    always @* begin
        cap_val = SHIFT_CAP[`SDL_SET_W-1:0]; // see (RL7)
        target  = (period_q > cap_val) ? cap_val : period_q;
        up      = set_bin_q < target; // see (RL16)
        down    = set_bin_q > target; // see (RL16)
    end

    always @* begin
        lock_target = low_jitter_in ? LOCK_LJ_CYC[CNT_W-1:0]
                                    : LOCK_NORM_CYC[CNT_W-1:0]; // see (RL3)
    end

    // Loop state machine
    always @* begin
        state_d   = state_q;
        set_bin_d = set_bin_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_LOCKING;
            end
            ST_LOCKING: begin
                if (lock_cnt_q >= lock_target - 13'h0001) begin
                    state_d = ST_TRACK; // see (RL4)
                end
            end
            ST_TRACK: begin
                state_d = ST_TRACK;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (upd_cnt_q == 3'h0 && state_q != ST_IDLE) begin
            if (up && set_bin_q != `SDL_SET_MAX) begin // see (RL24)
                set_bin_d = set_bin_q + 7'h01; // see (RL17)
            end else if (down && set_bin_q != `SDL_SET_RST) begin // see (RL24)
                set_bin_d = set_bin_q - 7'h01; // see (RL17)
            end
        end
    end

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state_q          <= ST_IDLE;
            set_bin_q        <= `SDL_SET_RST;
            lock_cnt_q       <= {CNT_W{1'b0}};
            upd_cnt_q        <= 3'h0;
            setting_gray_out <= `SDL_SET_RST;
            update_out       <= 1'b0;
            locked_out       <= 1'b0; // see (RL23)
        end else begin
            state_q   <= state_d;
            set_bin_q <= set_bin_d; // see (RL1)
            if (state_q == ST_LOCKING) begin
                lock_cnt_q <= lock_cnt_q + 13'h0001;
            end
            locked_out <= (state_d == ST_TRACK); // see (RL23)
            // Spaced update so all pins see a change together
            upd_cnt_q <= (upd_cnt_q == `SDL_UPD_GAP - 1) ? 3'h0
                                                          : upd_cnt_q + 3'h1;
            update_out <= (upd_cnt_q == 3'h0); // see (RL20)
            setting_gray_out <= set_bin_d ^ (set_bin_d >> 1); // see (RL2) (RL19)
        end
    end

    // Two offset units, one per adjacent side
    sdl_offset_unit u_ofs_a (
        .core_clk_in    (core_clk_in),
        .rstn_in        (rstn_in),
        .setting_bin_in (set_bin_q),
        .offset_gray_in (offset_a_gray_in),
        .offset_neg_in  (offset_a_neg_in),
        .update_in      (update_out),
        .adj_gray_out   (side_a_setting_out)
    ); // see (RL9) (RL12) (RL18)
    sdl_offset_unit u_ofs_b (
        .core_clk_in    (core_clk_in),
        .rstn_in        (rstn_in),
        .setting_bin_in (set_bin_q),
        .offset_gray_in (offset_b_gray_in),
        .offset_neg_in  (offset_b_neg_in),
        .update_in      (update_out),
        .adj_gray_out   (side_b_setting_out)
    ); // see (RL10) (RL11) (RL13)
endmodule // sdl_loop
`default_nettype wire

// file: sdl_loop_sva.sv
// Port checker for the strobe delay lock loop
`timescale 1ns/10ps
`default_nettype none
module sdl_loop_sva #(
    parameter integer LOCK_LJ_CYC   = 2560,
    parameter integer LOCK_NORM_CYC = 512
) (
    input wire logic       core_clk_in,
    input wire logic       rstn_in,
    input wire logic       low_jitter_in,
    input wire logic [6:0] setting_gray_out,
    input wire logic [7:0] side_a_setting_out,
    input wire logic [7:0] side_b_setting_out,
    input wire logic       update_out,
    input wire logic       locked_out
);
    logic [15:0] since_q;
    logic [15:0] need;
    function automatic logic [7:0] gdec(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int i = 6; i >= 0; i--) b[i] = b[i+1] ^ g[i];
        return b;
    endfunction
    assign need = low_jitter_in ? 16'(LOCK_LJ_CYC) : 16'(LOCK_NORM_CYC);
    always @(posedge core_clk_in) begin
        if (!rstn_in) since_q <= 16'h0000;
        else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_gap;
        !update_out [*3] ##1 update_out;
    endsequence
    sequence s_hold;
        $stable(setting_gray_out) [*3];
    endsequence
    AST_UPD_GAP: assert property (update_out |=> s_gap)
        else $error("update pulse spacing wrong");
    AST_GRAY_STEP: assert property (
        $countones(setting_gray_out ^ $past(setting_gray_out)) <= 1)
        else $error("setting changed more than one bit");
    AST_STEP_RATE: assert property (
        !$stable(setting_gray_out) |=> s_hold)
        else $error("setting stepped too fast");
    AST_SIDE_UPD: assert property (
        !$stable(side_a_setting_out) || !$stable(side_b_setting_out)
        |-> $past(update_out))
        else $error("side setting changed off update");
    AST_SIDE_CAP: assert property (
        gdec(side_a_setting_out) <= 8'h80
        && gdec(side_b_setting_out) <= 8'h80)
        else $error("side setting above cap");
    AST_LOCK_HOLD: assert property (locked_out |=> locked_out)
        else $error("lock dropped without reset");
    AST_LOCK_EARLY: assert property (
        locked_out |-> since_q >= need)
        else $error("lock came too early");
    AST_LOCK_LATE: assert property (
        since_q == need + 16'h0004 |-> locked_out)
        else $error("lock came too late");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        !rstn_in |=> !locked_out && !update_out
        && setting_gray_out == 7'h00)
        else $error("outputs not cleared by reset");
    AST_NO_WRAP: assert property (
        setting_gray_out == 7'h40 || setting_gray_out == 7'h00
        |=> setting_gray_out != ($past(setting_gray_out) ^ 7'h40))
        else $error("setting wrapped");
endmodule // sdl_loop_sva
bind sdl_loop sdl_loop_sva #(
    .LOCK_LJ_CYC   (LOCK_LJ_CYC),
    .LOCK_NORM_CYC (LOCK_NORM_CYC)
) u_sdl_loop_sva (
    .core_clk_in        (core_clk_in),
    .rstn_in            (rstn_in),
    .low_jitter_in      (low_jitter_in),
    .setting_gray_out   (setting_gray_out),
    .side_a_setting_out (side_a_setting_out),
    .side_b_setting_out (side_b_setting_out),
    .update_out         (update_out),
    .locked_out         (locked_out)
);
`default_nettype wire

// file: sdl_loop_tb_top.sv
// Testbench for the strobe delay lock loop
`timescale 1ns/10ps
`default_nettype none
module sdl_loop_tb_top;
    logic       clk;
    logic       rstn;
    logic       lj;
    logic       sel;
    logic [7:0] hpl;
    logic [7:0] hpn;
    logic [7:0] oa;
    logic [7:0] ob;
    logic       na;
    logic       nb;
    logic [7:0] va;
    logic [7:0] vb;
    wire        rpl;
    wire        rpn;
    wire  [6:0] sg;
    wire  [7:0] sa;
    wire  [7:0] sb;
    wire        upd;
    wire        lck;
    integer     miscompares;
    integer     num_checks;
    integer     seed;
    integer     i;
    integer     n;
    integer     exp_set;
    sdl_ref_src u_sdl_ref_src (
        .core_clk_in(clk), .half_in(hpl), .ref_out(rpl));
    sdl_ref_src u_sdl_ref_src_pin (
        .core_clk_in(clk), .half_in(hpn), .ref_out(rpn));
    sdl_loop #(.LOCK_LJ_CYC(40), .LOCK_NORM_CYC(16)) u_sdl_loop (
        .core_clk_in(clk), .rstn_in(rstn), .low_jitter_in(lj),
        .ref_sel_pin_in(sel), .ref_pll_in(rpl), .ref_pin_in(rpn),
        .chain_used_in(4'h7), .offset_a_gray_in(oa), .offset_a_neg_in(na),
        .offset_b_gray_in(ob), .offset_b_neg_in(nb), .setting_gray_out(sg),
        .side_a_setting_out(sa), .side_b_setting_out(sb),
        .update_out(upd), .locked_out(lck));
    function automatic logic [7:0] gdec(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int k = 6; k >= 0; k--) b[k] = b[k+1] ^ g[k];
        return b;
    endfunction
    function automatic logic [7:0] side_exp(input logic [7:0] v,
                                            input logic       s);
        integer t;
        t = exp_set;
        if (s == v[7]) t = t + $signed(v);
        if (t < 0) t = 0;
        if (t > 128) t = 128;
        return 8'(t) ^ (8'(t) >> 1);
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic restart(input logic m);
        @(posedge clk);
        rstn <= 1'b0;
        lj <= m;
        repeat (10) @(posedge clk);
        #1;
        check({lck, upd, sg}, 9'h000);
        @(posedge clk);
        rstn <= 1'b1;
        n = 0;
        while (lck !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        check(n >= (m ? 40 : 16) && n <= (m ? 44 : 20),
              9'h001);
    endtask
    task automatic track(input logic [7:0] p,
                         input logic [7:0] q,
                         input logic       s);
        integer e;
        @(posedge clk);
        hpl <= p;
        hpn <= q;
        sel <= s;
        repeat (800) @(posedge clk);
        #1;
        e = 2 * (s ? q : p);
        if (e > 127) e = 127;
        exp_set = e;
        check(gdec({1'b0, sg}), 9'(e));
    endtask
    task automatic offs(input logic [7:0] a, input logic x,
                        input logic [7:0] b, input logic y);
        @(posedge clk);
        oa <= a ^ (a >> 1);
        na <= x;
        ob <= b ^ (b >> 1);
        nb <= y;
        repeat (12) @(posedge clk);
        #1;
        check(sa, side_exp(a, x));
        check(sb, side_exp(b, y));
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares = miscompares + 1;
        conclude;
    end
    initial begin
        seed = 22;
        miscompares = 0;
        num_checks = 0;
        rstn = 1'b0;
        lj = 1'b0;
        sel = 1'b0;
        hpl = 8'h0a;
        hpn = 8'h14;
        {oa, ob, na, nb} = 18'h00000;
        restart(1'b0);
        track(8'h0a, 8'h14, 1'b0);
        track(8'h0a, 8'h14, 1'b1);
        track(8'h50, 8'h14, 1'b0);
        offs(8'h7f, 1'b0, 8'h80, 1'b1);
        track(8'h05, 8'h14, 1'b0);
        offs(8'hfb, 1'b1, 8'h05, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            va = 8'($random(seed));
            vb = 8'($random(seed));
            offs(va, va[7], vb, vb[7]);
        end
        restart(1'b1);
        va = 8'h04 + (8'($random(seed)) & 8'h1f);
        track(va, 8'h14, 1'b0);
        conclude;
    end
endmodule // sdl_loop_tb_top
`default_nettype wire

// file: sdl_offset_unit.v
// Phase offset unit: adds a Gray two's complement offset to the setting
`timescale 1ns/10ps
`default_nettype none
`include "sdl_consts.vh"
module sdl_offset_unit (
    input  wire                    core_clk_in,
    input  wire                    rstn_in,
    input  wire [`SDL_SET_W-1:0]   setting_bin_in,
    input  wire [`SDL_OFS_W-1:0]   offset_gray_in,
    input  wire                    offset_neg_in,
    input  wire                    update_in,
    output reg  [`SDL_SET_W:0]     adj_gray_out
);
    reg  [`SDL_OFS_W-1:0] ofs_bin;
    reg  [`SDL_SUM_W-1:0] sum;
    reg  [`SDL_SUM_W-1:0] sum_sat;
    reg  [`SDL_SET_W:0]   sum_trim;
    integer               i;

    always @* begin
        // Gray to binary for the whole two's complement offset, sign msb included
        ofs_bin[`SDL_OFS_W-1] = offset_gray_in[`SDL_OFS_W-1];
        for (i = `SDL_OFS_W-2; i >= 0; i = i - 1) begin
            ofs_bin[i] = ofs_bin[i+1] ^ offset_gray_in[i];
        end
        // Sign bit must agree with the two's complement msb
        if (offset_neg_in != ofs_bin[`SDL_OFS_W-1]) begin // see (RL21)
            ofs_bin = {`SDL_OFS_W{1'b0}};
        end
        sum = {2'b00, setting_bin_in}
            + {ofs_bin[`SDL_OFS_W-1], ofs_bin}; // see (RL22)
        if (sum[`SDL_SUM_W-1]) begin
            sum_sat = {`SDL_SUM_W{1'b0}};
        end else if (sum > `SDL_SUM_CAP) begin
            sum_sat = `SDL_SUM_CAP; // see (RL22)
        end else begin
            sum_sat = sum;
        end
        sum_trim = sum_sat[`SDL_SET_W:0];
    end

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            adj_gray_out <= {(`SDL_SET_W+1){1'b0}};
        end else if (update_in) begin // see (RL20)
            adj_gray_out <= sum_trim ^ (sum_trim >> 1); // see (RL21)
        end
    end
endmodule // sdl_offset_unit
`default_nettype wire

// file: sdl_ref_src.sv
// Reference clock source model for one loop reference input
`timescale 1ns/10ps
`default_nettype none
module sdl_ref_src (
    input  wire logic       core_clk_in,
    input  wire logic [7:0] half_in,
    output var  logic       ref_out
);
    logic [7:0] cnt_q = 8'h00;
    initial ref_out = 1'b0;
    // Level flips after half_in core cycles
    always @(posedge core_clk_in) begin
        if (cnt_q + 8'h01 >= half_in) begin
            cnt_q   <= 8'h00;
            ref_out <= ~ref_out;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // sdl_ref_src
`default_nettype wire
